// ### core/palette_gamma_unit.sv
`timescale 1ns/1ps
module palette_gamma_unit
   import palette_pkg::*;
#(
   parameter int PIPE = 0
) (
   input  wire logic              clock,
   input  wire logic              rst_n,
   input  wire logic [1:0]        gamma_mode,
   input  wire max_point_t        max_reference_point,
   input  wire pixel_t            pix_in,
   output logic                   out_valid,
   output logic [PIX_W-1:0]       out_data,
   input  wire mmio_req_t         mmio_req,
   output logic                   mmio_rvalid,
   output logic [31:0]            mmio_rdata,
   input  wire vga_req_t          vga_req,
   output logic                   vga_done,
   output logic [17:0]            vga_rdata
);

   if (PIPE != 0 && PIPE != 1) begin : g_bad
      $error("palette_gamma_unit: PIPE must be 0 or 1");
   end

   localparam logic [19:0] LEG_BASE  = (PIPE == 0) ? LEG_A_BASE : LEG_B_BASE;
   localparam logic [19:0] PREC_BASE = (PIPE == 0) ? PREC_A_BASE : PREC_B_BASE;
   localparam int LEG_AW = $clog2(LEG_ENTRIES);
   localparam int PT_AW  = $clog2(POINTS);
   localparam int LEG_RD = NCOMP + 2;
   localparam int PT_RD  = 2 * NCOMP + 1;

   typedef struct packed {
      logic                         s1_valid;
      logic                         s1_gamma_en;
      logic [PIX_W-1:0]             s1_data;
      lut_mode_t                    s1_mode;
      logic [NCOMP-1:0]             s1_sel;
      logic [NCOMP-1:0][2:0]        s1_frac;
      logic [NCOMP-1:0]             s1_last;
      logic                         s1_rd_leg;
      logic                         s1_rd_prec;
      logic                         s1_rd_bank;
      logic                         s1_rd_mask;
      logic                         s1_rd_any;
      logic                         s1_vga_acc;
      logic                         s1_vga_rd;
      logic                         out_valid;
      logic [PIX_W-1:0]             out_data;
      logic                         mmio_rvalid;
      logic [31:0]                  mmio_rdata;
      logic                         vga_done;
      logic [17:0]                  vga_rdata;
   } state_t;

   state_t st_q;
   state_t st_d;

   // ---------------------------------------------------------------
   // Tables
   // ---------------------------------------------------------------
   logic                             leg_we;
   logic [LEG_AW-1:0]                leg_waddr;
   logic [LEG_W-1:0]                 leg_wdata;
   logic [LEG_RD-1:0][LEG_AW-1:0]    leg_raddr;
   logic [LEG_RD-1:0][LEG_W-1:0]     leg_rdata;
   logic [1:0]                       pt_we;
   logic [PT_AW-1:0]                 pt_waddr;
   logic [PREC_W-1:0]                pt_wdata;
   logic [PT_RD-1:0][PT_AW-1:0]      pt_raddr;
   logic [1:0][PT_RD-1:0][PREC_W-1:0] pt_rdata;

   point_ram #(
      .W     (LEG_W),
      .DEPTH (LEG_ENTRIES),
      .NRD   (LEG_RD)
   ) u_legacy (
      .clock (clock),
      .rst_n (rst_n),
      .we    (leg_we),
      .waddr (leg_waddr),
      .wdata (leg_wdata),
      .raddr (leg_raddr),
      .rdata (leg_rdata)
   );

   // Bank 0 holds even dwords, bank 1 odd dwords
   for (genvar b = 0; b < 2; b++) begin : g_bank
      point_ram #(
         .W     (PREC_W),
         .DEPTH (POINTS),
         .NRD   (PT_RD)
      ) u_points (
         .clock (clock),
         .rst_n (rst_n),
         .we    (pt_we[b]),
         .waddr (pt_waddr),
         .wdata (pt_wdata),
         .raddr (pt_raddr),
         .rdata (pt_rdata[b])
      );
   end

   // ---------------------------------------------------------------
   // Host decode
   // ---------------------------------------------------------------
   logic [19:0] leg_off;
   logic [19:0] prec_off;
   logic        leg_hit;
   logic        prec_hit;
   logic        mmio_full;
   logic        mmio_leg_wr;
   logic        vga_acc;
   lut_mode_t   mode_now;

   assign leg_off   = mmio_req.addr - LEG_BASE;
   assign prec_off  = mmio_req.addr - PREC_BASE;
   assign leg_hit   = mmio_req.valid && leg_off < LEG_SPAN;
   assign prec_hit  = mmio_req.valid && prec_off < PREC_SPAN;
   assign mmio_full = mmio_req.byte_en == FULL_DWORD;
   assign mmio_leg_wr = leg_hit && mmio_req.write && mmio_full;
   // A VGA write colliding with an MMIO legacy write is refused; VGA reads still proceed
   assign vga_acc   = vga_req.valid && !(vga_req.write && mmio_leg_wr);

   always_comb begin
      unique case (gamma_mode)
         MODE_PREC10: mode_now = LUT_PREC10;
         MODE_INTERP: mode_now = LUT_INTERP;
         default:     mode_now = LUT_LEGACY;
      endcase
   end

   // ---------------------------------------------------------------
   // Write ports and read addresses
   // ---------------------------------------------------------------
   always_comb begin
      leg_we    = mmio_leg_wr || (vga_acc && vga_req.write);
      leg_waddr = mmio_leg_wr ? leg_off[9:2] : vga_req.index;
      leg_wdata = mmio_req.wdata[LEG_W-1:0];
      if (!mmio_leg_wr) begin
         // Six-bit VGA components padded with zero LSBs
         for (int c = 0; c < NCOMP; c++) begin
            leg_wdata[c*LEG_CW +: LEG_CW] =
               {vga_req.wdata[c*VGA_CW +: VGA_CW], 2'h0};
         end
      end
      pt_we    = '0;
      pt_waddr = prec_off[11:3];
      pt_wdata = mmio_req.wdata[PREC_W-1:0];
      if (prec_hit && mmio_req.write && mmio_full) begin
         pt_we[prec_off[2]] = 1'b1;
      end
      leg_raddr[NCOMP]     = leg_off[9:2];
      leg_raddr[NCOMP + 1] = vga_req.index;
      pt_raddr[2*NCOMP]    = prec_off[11:3];
      for (int c = 0; c < NCOMP; c++) begin
         // Legacy gamma keeps the top 8 bits of each component, or uses data[7:0] for all when indexed
         leg_raddr[c] = pix_in.indexed ? pix_in.data[7:0]
                      : pix_in.data[c*COMP_W + 4 +: LEG_CW];
         // Point k sits at this address, k+1 one above
         pt_raddr[2*c] = pix_in.data[c*COMP_W + STEP_BITS +: PT_AW];
         if (mode_now == LUT_PREC10) begin
            pt_raddr[2*c] = pix_in.data[c*COMP_W + 3 +: PT_AW];
         end
         pt_raddr[2*c+1] = pt_raddr[2*c] + 9'h001;
      end
   end

   // ---------------------------------------------------------------
   // Lookup results per component
   // ---------------------------------------------------------------
   logic [NCOMP-1:0][MAX_W-1:0]  p0_w;
   logic [NCOMP-1:0][MAX_W-1:0]  p1_w;
   logic [NCOMP-1:0][COMP_W-1:0] comp_w;
   logic [MAX_W-1:0]             max_pt [NCOMP];

   assign max_pt[0] = max_reference_point.blue;
   assign max_pt[1] = max_reference_point.green;
   assign max_pt[2] = max_reference_point.red;

   for (genvar c = 0; c < NCOMP; c++) begin : g_comp
      logic [PREC_W-1:0] ev0;
      logic [PREC_W-1:0] od0;
      logic [PREC_W-1:0] ev1;
      logic [PREC_W-1:0] od1;
      logic [PREC_W-1:0] word10;
      logic [3:0]        w0;
      logic [3:0]        w1;
      logic [20:0]       acc;
      logic [17:0]       res;

      assign ev0 = pt_rdata[0][2*c];
      assign od0 = pt_rdata[1][2*c];
      assign ev1 = pt_rdata[0][2*c+1];
      assign od1 = pt_rdata[1][2*c+1];
      // 12.4 point from odd base 11:2, even base 1:0 and fraction
      assign p0_w[c] = {1'b0, od0[c*PREC_CW +: PREC_CW],
                        ev0[c*PREC_CW + EVEN_BASE_LSB +: 2],
                        ev0[c*PREC_CW + EVEN_FRAC_LSB +: FRAC_W]};
      // The 513th point is not in the RAM
      assign p1_w[c] = st_q.s1_last[c] ? max_pt[c]
                     : {1'b0, od1[c*PREC_CW +: PREC_CW],
                        ev1[c*PREC_CW + EVEN_BASE_LSB +: 2],
                        ev1[c*PREC_CW + EVEN_FRAC_LSB +: FRAC_W]};
      assign w1  = {1'b0, st_q.s1_frac[c]};
      assign w0  = 4'h8 - w1;
      assign acc = 21'(p0_w[c]) * 21'(w0)
                 + 21'(p1_w[c]) * 21'(w1);
      assign res = acc[20:3];
      assign word10 = st_q.s1_sel[c] ? od0 : ev0;

      always_comb begin
         unique case (st_q.s1_mode)
            LUT_LEGACY: comp_w[c] =
               {leg_rdata[c][c*LEG_CW +: LEG_CW], 4'h0};
            LUT_PREC10: comp_w[c] =
               {word10[c*PREC_CW +: PREC_CW], 2'h0};
            LUT_INTERP: comp_w[c] =
               (res[17:16] != 2'h0) ? 12'hfff : res[15:4];
            default:    comp_w[c] = '0;
         endcase
      end
   end

   // ---------------------------------------------------------------
   // Next state
   // ---------------------------------------------------------------
   always_comb begin
      st_d = st_q;
      // Stage 1: capture what the stage-2 mux needs
      st_d.s1_valid    = pix_in.valid;
      st_d.s1_gamma_en = pix_in.gamma_en;
      st_d.s1_data     = pix_in.data;
      st_d.s1_mode     = mode_now;
      for (int c = 0; c < NCOMP; c++) begin
         st_d.s1_sel[c]  = pix_in.data[c*COMP_W + 2];
         st_d.s1_frac[c] = pix_in.data[c*COMP_W +: STEP_BITS];
         st_d.s1_last[c] =
            pix_in.data[c*COMP_W + STEP_BITS +: PT_AW] == 9'h1ff;
      end
      st_d.s1_rd_any  = mmio_req.valid && !mmio_req.write;
      st_d.s1_rd_leg  = leg_hit && !mmio_req.write;
      st_d.s1_rd_prec = prec_hit && !mmio_req.write;
      st_d.s1_rd_bank = prec_off[2];
      st_d.s1_rd_mask = mode_now == LUT_INTERP && !prec_off[2];
      st_d.s1_vga_acc = vga_acc;
      st_d.s1_vga_rd  = vga_acc && !vga_req.write;

      // Stage 2: registered outputs
      st_d.out_valid = st_q.s1_valid;
      st_d.out_data  = st_q.s1_data;
      if (st_q.s1_gamma_en) begin
         st_d.out_data = comp_w;
      end
      st_d.mmio_rvalid = st_q.s1_rd_any;
      st_d.mmio_rdata  = '0;
      if (st_q.s1_rd_leg) begin
         st_d.mmio_rdata = {8'h0, leg_rdata[NCOMP]};
      end else if (st_q.s1_rd_prec) begin
         st_d.mmio_rdata = {2'h0, pt_rdata[st_q.s1_rd_bank][2*NCOMP]};
         if (st_q.s1_rd_mask) begin
            st_d.mmio_rdata[PREC_W-1:0] =
               st_d.mmio_rdata[PREC_W-1:0] & ~EVEN_RSVD_MASK;
         end
      end
      st_d.vga_done = st_q.s1_vga_acc;
      if (st_q.s1_vga_rd) begin
         for (int c = 0; c < NCOMP; c++) begin
            st_d.vga_rdata[c*VGA_CW +: VGA_CW] =
               leg_rdata[NCOMP+1][c*LEG_CW + 2 +: VGA_CW];
         end
      end
   end

   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         st_q <= state_t'(0);
      end else begin
         st_q <= st_d;
      end
   end

   assign out_valid   = st_q.out_valid;
   assign out_data    = st_q.out_data;
   assign mmio_rvalid = st_q.mmio_rvalid;
   assign mmio_rdata  = st_q.mmio_rdata;
   assign vga_done    = st_q.vga_done;
   assign vga_rdata   = st_q.vga_rdata;

   // ---------------------------------------------------------------
   // Assertions
   // ---------------------------------------------------------------
   default clocking cb @(posedge clock); endclocking
   default disable iff (!rst_n);
   sequence s_pix_taken;
      pix_in.valid && pix_in.gamma_en;
   endsequence
   sequence s_legacy_taken;
      s_pix_taken ##0 mode_now == LUT_LEGACY;
   endsequence
   a_bypass_exact: assert property (
      pix_in.valid && !pix_in.gamma_en |-> ##2
      out_valid && out_data == $past(pix_in.data, 2))
      else $error("bypassed pixel altered");
   a_stream_latency: assert property (
      out_valid == $past(pix_in.valid, 2))
      else $error("pixel latency wrong");
   a_legacy_pad: assert property (
      s_legacy_taken |-> ##2 out_data[3:0] == 4'h0 &&
      out_data[15:12] == 4'h0 && out_data[27:24] == 4'h0)
      else $error("legacy result not padded");
   a_prec_pad: assert property (
      s_pix_taken ##0 mode_now == LUT_PREC10 |-> ##2
      out_data[1:0] == 2'h0 && out_data[13:12] == 2'h0 &&
      out_data[25:24] == 2'h0)
      else $error("ten-bit result not padded");
   a_dword_only: assert property (
      (pt_we != 2'h0) || mmio_leg_wr |-> mmio_req.byte_en == FULL_DWORD)
      else $error("partial write reached palette");
   a_legacy_rsvd: assert property (
      leg_hit && !mmio_req.write |-> ##2
      mmio_rvalid && mmio_rdata[31:24] == 8'h0)
      else $error("legacy reserved bits nonzero");
   a_prec_rsvd: assert property (
      prec_hit && !mmio_req.write |-> ##2
      mmio_rvalid && mmio_rdata[31:30] == 2'h0)
      else $error("precision reserved bits nonzero");
   a_even_mask: assert property (
      prec_hit && !mmio_req.write && mode_now == LUT_INTERP &&
      !prec_off[2] |-> ##2 (mmio_rdata[29:0] & EVEN_RSVD_MASK) == 30'h0)
      else $error("even dword reserved bits shown");
   a_vga_done: assert property (
      vga_acc |-> ##2 vga_done)
      else $error("vga access not completed");
   a_interp_frac0: assert property (
      st_q.s1_valid && st_q.s1_gamma_en && st_q.s1_mode == LUT_INTERP &&
      st_q.s1_frac[2] == 3'h0 && !p0_w[2][16] |=>
      out_data[35:24] == $past(p0_w[2][15:4]))
      else $error("interpolation at a point is wrong");
   a_max_select: assert property (
      st_q.s1_last[0] |-> p1_w[0] == max_reference_point.blue)
      else $error("last point not from max register");

endmodule // palette_gamma_unit

// ### core/palette_pkg.sv
package palette_pkg;

   // ---------------------------------------------------------------
   // Pixel and table geometry
   // ---------------------------------------------------------------
   localparam int PIX_W       = 36;
   localparam int COMP_W      = 12;
   localparam int NCOMP       = 3;
   localparam int LEG_ENTRIES = 256;
   localparam int LEG_W       = 24;
   localparam int LEG_CW      = 8;
   localparam int VGA_CW      = 6;
   localparam int PREC_DWORDS = 1024;
   localparam int PREC_W      = 30;
   localparam int PREC_CW     = 10;
   localparam int POINTS      = 512;
   localparam int REF_W       = 16;
   localparam int MAX_W       = 17;
   localparam int FRAC_W      = 4;
   localparam int STEP_BITS   = 3;

   // ---------------------------------------------------------------
   // Register offsets (byte addresses)
   // ---------------------------------------------------------------
   localparam int ADDR_W = 20;
   localparam logic [19:0] LEG_A_BASE  = 20'h4a000;
   localparam logic [19:0] LEG_B_BASE  = 20'h4a800;
   localparam logic [19:0] PREC_A_BASE = 20'h4b000;
   localparam logic [19:0] PREC_B_BASE = 20'h4c000;
   localparam logic [19:0] LEG_SPAN    = 20'h00400;
   localparam logic [19:0] PREC_SPAN   = 20'h01000;

   // ---------------------------------------------------------------
   // Field positions
   // ---------------------------------------------------------------
   // Component c field lsb is c * field width (blue = 0, red = 2)
   localparam int EVEN_BASE_LSB = 8;
   localparam int EVEN_FRAC_LSB = 4;
   localparam logic [29:0] EVEN_RSVD_MASK = 30'h00f03c0f;
   localparam logic [3:0]  FULL_DWORD     = 4'hf;

   // Palette/gamma unit mode field of the pipe configuration
   localparam logic [1:0] MODE_LEGACY = 2'h0;
   localparam logic [1:0] MODE_PREC10 = 2'h1;
   localparam logic [1:0] MODE_INTERP = 2'h2;

   // Pixel in to pixel out, and host request to answer
   localparam int PIX_LATENCY  = 2;
   localparam int HOST_LATENCY = 2;

   typedef enum logic [2:0] {
      LUT_LEGACY = 3'h1,
      LUT_PREC10 = 3'h2,
      LUT_INTERP = 3'h4
   } lut_mode_t;

   typedef struct packed {
      logic              valid;
      logic              gamma_en;
      logic              indexed;
      logic [PIX_W-1:0]  data;
   } pixel_t;

   typedef struct packed {
      logic              valid;
      logic              write;
      logic [ADDR_W-1:0] addr;
      logic [3:0]        byte_en;
      logic [31:0]       wdata;
   } mmio_req_t;

   typedef struct packed {
      logic              valid;
      logic              write;
      logic [7:0]        index;
      logic [17:0]       wdata;
   } vga_req_t;

   typedef struct packed {
      logic [MAX_W-1:0]  red;
      logic [MAX_W-1:0]  green;
      logic [MAX_W-1:0]  blue;
   } max_point_t;

endpackage

// ### core/point_ram.sv
`timescale 1ns/1ps
module point_ram
   import palette_pkg::*;
#(
   parameter int W     = 24,
   parameter int DEPTH = 256,
   parameter int NRD   = 1,
   localparam int AW   = $clog2(DEPTH)
) (
   input  wire logic                    clock,
   input  wire logic                    rst_n,
   input  wire logic                    we,
   input  wire logic [AW-1:0]           waddr,
   input  wire logic [W-1:0]            wdata,
   input  wire logic [NRD-1:0][AW-1:0]  raddr,
   output logic      [NRD-1:0][W-1:0]   rdata
);

   if (NRD < 1 || DEPTH < 2 || (1 << AW) != DEPTH) begin : g_bad
      $error("point_ram: bad depth or port count");
   end

   // Contents are left uninitialised, like the real palette
   logic [W-1:0] mem [DEPTH];

   always_ff @(posedge clock) begin
      if (we) begin
         mem[waddr] <= wdata;
      end
   end

   // ---------------------------------------------------------------
   // Registered read ports
   // ---------------------------------------------------------------
   for (genvar p = 0; p < NRD; p++) begin : g_rd
      always_ff @(posedge clock or negedge rst_n) begin
         if (!rst_n) begin
            rdata[p] <= '0;
         end else begin
            rdata[p] <= mem[raddr[p]];
         end
      end
   end

endmodule // point_ram

// ### test/blender_model.sv
`timescale 1ns/1ps
module blender_model
   import palette_pkg::*;
(
   input  wire logic             clock,
   output pixel_t                pix,
   input  wire logic             out_valid,
   input  wire logic [PIX_W-1:0] out_data
);
   // ------------------------------------------------------------
   // Upstream blender and downstream pipe
   // ------------------------------------------------------------
   initial pix = '0;

   // One pixel in, its result two cycles on; no back-pressure
   task automatic send(input logic en,
                       input logic idx,
                       input logic [PIX_W-1:0] d,
                       output logic v,
                       output logic [PIX_W-1:0] q);
      @(posedge clock);
      pix <= '{1'b1, en, idx, d};
      @(posedge clock);
      // Idle lines must not repeat the last pixel
      pix <= '{1'b0, ~en, ~idx, ~d};
      @(posedge clock);
      @(negedge clock);
      v = out_valid;
      q = out_data;
   endtask
endmodule // blender_model

// ### test/tb.sv
`timescale 1ns/1ps
module tb;
   import palette_pkg::*;
   logic             clock = 1'b0;
   logic             rst_n = 1'b0;
   logic [1:0]       gamma_mode;
   max_point_t       max_pt;
   pixel_t           pix;
   logic             out_valid;
   logic [PIX_W-1:0] out_data;
   mmio_req_t        mreq;
   logic             rv;
   logic [31:0]      rdata;
   vga_req_t         vreq;
   logic             vdone;
   logic [17:0]      vrdata;
   int               fails = 0;
   int               checks_done = 0;
   int               cycles = 0;
   int               i;
   logic [23:0]      e1, e2, e3;
   logic [11:0]      ek;

   always #5 clock = ~clock;

   palette_gamma_unit #(.PIPE(0)) palette_gamma_unit_inst (
      .clock(clock), .rst_n(rst_n), .gamma_mode(gamma_mode),
      .max_reference_point(max_pt), .pix_in(pix),
      .out_valid(out_valid), .out_data(out_data), .mmio_req(mreq),
      .mmio_rvalid(rv), .mmio_rdata(rdata), .vga_req(vreq),
      .vga_done(vdone), .vga_rdata(vrdata));

   blender_model blender_model_inst (
      .clock(clock), .pix(pix), .out_valid(out_valid),
      .out_data(out_data));

   // ------------------------------------------------------------
   // Checking and closing
   // ------------------------------------------------------------
   task automatic chk(input logic [35:0] got, input logic [35:0] exp);
      checks_done++;
      if (got !== exp) begin
         fails++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   task automatic end_of_test();
      $display("checks_done=%0d fails=%0d", checks_done, fails);
      if (fails == 0 && checks_done > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask

   // Whole run is about 600 cycles
   always @(posedge clock) begin
      cycles++;
      if (cycles == 5000) begin
         fails++;
         end_of_test();
      end
   end

   // ------------------------------------------------------------
   // Access tasks
   // ------------------------------------------------------------
   task automatic wr(input logic [19:0] a, input logic [3:0] be,
                     input logic [31:0] d);
      @(posedge clock);
      mreq <= '{1'b1, 1'b1, a, be, d};
      @(posedge clock);
      mreq <= '{1'b0, 1'b0, a, be, ~d};
   endtask

   task automatic rd_chk(input logic [19:0] a, input logic [31:0] exp);
      @(posedge clock);
      mreq <= '{1'b1, 1'b0, a, 4'hf, 32'h0};
      @(posedge clock);
      mreq.valid <= 1'b0;
      @(posedge clock);
      @(negedge clock);
      chk({35'h0, rv}, 36'h1);
      chk({4'h0, rdata}, {4'h0, exp});
   endtask

   task automatic vga(input logic w, input logic [7:0] ix,
                      input logic [17:0] d, input logic [17:0] exp);
      @(posedge clock);
      vreq <= '{1'b1, w, ix, d};
      @(posedge clock);
      vreq <= '{1'b0, w, ix, ~d};
      @(posedge clock);
      @(negedge clock);
      chk({35'h0, vdone}, 36'h1);
      if (!w) chk({18'h0, vrdata}, {18'h0, exp});
   endtask

   task automatic px(input logic en, input logic idx,
                     input logic [35:0] d, input logic [35:0] exp);
      logic        v;
      logic [35:0] q;
      blender_model_inst.send(en, idx, d, v, q);
      chk({35'h0, v}, 36'h1);
      chk(q, exp);
   endtask

   // One reference point: even dword low bits, odd dword high bits
   task automatic pt(input logic [8:0] k, input logic [15:0] p);
      logic [9:0]  ef;
      logic [19:0] a;
      ef = {p[5:4], p[3:0], 4'h0};
      a = PREC_A_BASE + {8'h0, k, 3'h0};
      wr(a, 4'hf, {2'b0, ef, ef, ef} | 32'(EVEN_RSVD_MASK));
      rd_chk(a, {2'b0, ef, ef, ef});
      wr(a + 20'h4, 4'hf, {2'b0, p[15:6], p[15:6], p[15:6]});
   endtask

   function automatic logic [23:0] leg(input logic [7:0] n);
      return {~n, n + 8'h1, n ^ 8'h5a};
   endfunction

   function automatic logic [11:0] ip(input logic [16:0] p0,
                                      input logic [16:0] p1,
                                      input logic [2:0] f);
      logic [20:0] s;
      s = (p0 * (21'h8 - f) + p1 * f) >> 3;
      return (s[20:16] != 5'h0) ? 12'hfff : s[15:4];
   endfunction

   // ------------------------------------------------------------
   // Tests
   // ------------------------------------------------------------
   initial begin
      mreq = '0;
      vreq = '0;
      gamma_mode = MODE_LEGACY;
      max_pt = '{17'h10000, 17'h10000, 17'h10000};
      repeat (20) @(posedge clock);
      rst_n <= 1'b1;
      for (i = 0; i < LEG_ENTRIES; i++) begin
         wr(LEG_A_BASE + 20'(i * 4), 4'hf, {8'hff, leg(8'(i))});
      end
      wr(LEG_A_BASE + 20'h00c, 4'h3, 32'h0);
      rd_chk(LEG_A_BASE + 20'h00c, {8'h0, leg(8'h03)});
      rd_chk(LEG_A_BASE + 20'h3fc, {8'h0, leg(8'hff)});
      rd_chk(20'h4a400, 32'h0);
      $display("test legacy table done");
      vga(1'b1, 8'h40, 18'h3f06a, 18'h0);
      rd_chk(LEG_A_BASE + 20'h100, 32'h00fc04a8);
      vga(1'b0, 8'h40, 18'h0, 18'h3f06a);
      // A VGA write meeting an MMIO write to the same entry is dropped
      @(posedge clock);
      mreq <= '{1'b1, 1'b1, LEG_A_BASE + 20'h040, 4'hf, 32'h00123456};
      vreq <= '{1'b1, 1'b1, 8'h10, 18'h0};
      @(posedge clock);
      mreq.valid <= 1'b0;
      vreq.valid <= 1'b0;
      @(posedge clock);
      @(negedge clock);
      chk({35'h0, vdone}, 36'h0);
      rd_chk(LEG_A_BASE + 20'h040, 32'h00123456);
      $display("test vga path done");
      e1 = leg(8'h12);
      e2 = leg(8'h34);
      e3 = leg(8'h56);
      px(1'b1, 1'b0, 36'h12f34a565, {e1[23:16], 4'h0, e2[15:8], 4'h0,
         e3[7:0], 4'h0});
      e1 = leg(8'h9c);
      px(1'b1, 1'b1, 36'hfffffff9c, {e1[23:16], 4'h0, e1[15:8], 4'h0,
         e1[7:0], 4'h0});
      px(1'b0, 1'b0, 36'h123456789, 36'h123456789);
      $display("test legacy lookup done");
      @(posedge clock);
      gamma_mode <= MODE_PREC10;
      wr(PREC_A_BASE + 20'h0d4, 4'hf, 32'hea55a0f0);
      rd_chk(PREC_A_BASE + 20'h0d4, 32'h2a55a0f0);
      px(1'b1, 1'b0, 36'h0d70d70d7, {10'h2a5, 2'b0, 10'h168, 2'b0,
         10'h0f0, 2'b0});
      $display("test ten-bit done");
      @(posedge clock);
      gamma_mode <= MODE_INTERP;
      pt(9'h005, 16'h1238);
      pt(9'h006, 16'h1a4f);
      ek = ip(17'h01238, 17'h01a4f, 3'h3);
      px(1'b1, 1'b0, 36'h02b02b02b, {ek, ek, ek});
      pt(9'h1ff, 16'hff00);
      ek = ip(17'h0ff00, 17'h10000, 3'h4);
      px(1'b1, 1'b0, 36'hffcffcffc, {ek, ek, ek});
      $display("test interpolated done");
      // Unused mode code falls back to the legacy table
      @(posedge clock);
      gamma_mode <= 2'h3;
      px(1'b1, 1'b1, 36'h00000009c, {e1[23:16], 4'h0, e1[15:8], 4'h0,
         e1[7:0], 4'h0});
      $display("test spare mode done");
      end_of_test();
   end
endmodule // tb
